// ---- hdl/cec_pkg.sv ----
package cec_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ON_HOLD_MS = 2000;
  localparam int unsigned MODE_HOLD_MS = 3000;
  localparam int unsigned IDLE_TIMEOUT_MS = 3000;
  localparam int unsigned TENTH_HOUR_S = 360;
  localparam int unsigned ON_HOLD_CYC = ON_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned MODE_HOLD_CYC = MODE_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam longint unsigned TENTH_HOUR_CYC = longint'(TENTH_HOUR_S) * CLK_HZ;
  // Defaults of settings
  localparam logic [15:0] ENGAGE_RPM_DEF = 16'd900;
  localparam logic [15:0] WARN_PUMP_DEF = 16'd3650;
  localparam logic [15:0] WARN_CLEAR_PUMP = 16'd3600;
  localparam logic [15:0] CUT_PUMP_DEF = 16'd4500;
  localparam logic [15:0] OIL_WARN_DEF = 16'd212;
  localparam logic [15:0] OIL_CUT_DEF = 16'd240;
  localparam logic [15:0] PRESS_LIMIT_PSI = 16'd10;
  localparam logic [17:0] HOURS_MAX = 18'd99999;
  // Pump ratio in hundredths
  localparam logic [15:0] RATIO_A = 16'd244;
  localparam logic [15:0] RATIO_B = 16'd267;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ENG_RPM = 8'h04;
  localparam logic [7:0] A_WARN_PUMP = 8'h08;
  localparam logic [7:0] A_CUT_PUMP = 8'h0c;
  localparam logic [7:0] A_OIL_WARN = 8'h10;
  localparam logic [7:0] A_OIL_CUT = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_FAULT = 8'h1c;
  localparam logic [7:0] A_HOURS = 8'h20;
  // CTRL fields
  localparam int CTRL_UNIT_C = 0;
  localparam int CTRL_PRESS_LO = 1;
  localparam int CTRL_RATIO = 3;
  localparam int CTRL_AUTO_ON = 4;
  localparam int CTRL_SRC_PULSE = 5;
  // Fault codes
  localparam logic [3:0] F_NONE = 4'h0;
  localparam logic [3:0] F_NO_RPM = 4'h3;
  localparam logic [3:0] F_NO_PRESS = 4'h5;
  localparam logic [3:0] F_NO_TEMP = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    CEC_VIEW_RPM = 3'b001,
    CEC_VIEW_AIR = 3'b010,
    CEC_VIEW_HRS = 3'b100
  } cec_view_e;
  typedef enum logic [1:0] {
    CEC_RUN = 2'b01,
    CEC_SET = 2'b10
  } cec_mode_e;
endpackage : cec_pkg

// ---- hdl/cec_top.sv ----
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
// How it works
// - Engage only when engine speed is at or below the engagement limit (900).
// - Engage only while air pressure is below 10 psi.
// - Engage only while oil temperature is below the 212 F warning level.
// - On/off button must be held 2 s to turn on, and 2 s to turn off.
// - On/off button is ignored while interlock is inactive.
// - Auto-start engages on interlock when conditions hold; button still turns off.
// - Engaged LED lights only with all conditions met and clutch driven.
// - Drop clutch and show cutout message above disengage speed over pump ratio.
// - Overspeed LED sets above 3650/ratio, clears at 3600/ratio.
// - High speed warning between warning and disengage thresholds, no disengage.
// - Compressor hot warning between oil warning and shutdown settings.
// - Above oil shutdown setting (240 F) disengage and show shutdown hot.
// - Low foam or transmission hot disengage, sound buzzer, show message.
// - Fault codes E3 no speed, E5 no pressure, E10 no temperature.
// - Buzzer sounds on overspeed, oil hot, transmission hot or low foam.
// - Bleed message when engagement is tried at or above 10 psi.
// - Hours counted while engaged in 0.1 h steps up to 9999.9, kept.
// - Mode press cycles view speed, airflow, hours; speed is default.
// - Mode held 3 s enters settings; both held 3 s leave it.
// - Ratio setting picks 2.44 (default) or the alternative.
// - Settings hold engagement limit, speed thresholds and oil limits.
// - Settings select F or C and psi, kPa or bar display units.
// - Speed from alternator pulses or data bus, data bus by default.
// - Settings mode returns to normal after 3 s without button input.
module cec_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Sensors
  input wire logic [15:0] BUS_RPM,
  input wire logic BUS_RPM_VALID,
  input wire logic [15:0] PULSE_RPM,
  input wire logic PULSE_RPM_VALID,
  input wire logic [15:0] AIR_PSI,
  input wire logic PRESS_PRESENT,
  input wire logic [15:0] OIL_F,
  input wire logic TEMP_PRESENT,
  input wire logic INTERLOCK,
  input wire logic AGENT_LEVEL_LOW,
  input wire logic TRANS_HOT,
  // Buttons
  input wire logic BTN_ONOFF,
  input wire logic BTN_MODE,
  // Outputs
  output logic CLUTCH,
  output logic ENGAGED_LED,
  output logic OVERSPEED_LED,
  output logic BUZZER,
  output logic SPEED_HIGH_WARNING,
  output logic SPEED_CUTOUT_MESSAGE,
  output logic OIL_HOT_WARNING,
  output logic OIL_SHUTDOWN_MESSAGE,
  output logic AGENT_SHUTDOWN_MESSAGE,
  output logic TRANS_SHUTDOWN_MESSAGE,
  output logic PRESSURE_BLEED_PENDING,
  output logic AIR_PRESSURE_HIGH,
  output logic [3:0] FAULT_CODE,
  output logic [2:0] VIEW,
  output logic SETTINGS_MODE
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic w_stb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ctrl;
    logic [15:0] eng_rpm;
    logic [15:0] warn_pump;
    logic [15:0] cut_pump;
    logic [15:0] oil_warn;
    logic [15:0] oil_cut;
    logic on;
    logic clutch;
    logic engaged;
    logic ovs_led;
    logic [24:0] on_cnt;
    logic on_done;
    logic [24:0] mode_cnt;
    logic mode_done;
    logic [24:0] both_cnt;
    logic both_done;
    logic [24:0] idle_cnt;
    logic mode_q;
    logic ilk_q;
    logic bleed;
    logic [31:0] tenth_cnt;
    logic [17:0] hours;
    cec_pkg::cec_view_e view;
    cec_pkg::cec_mode_e mode;
    logic [3:0] fault;
    logic [10:0] outs;
  } cec_state_s;

  cec_state_s s_reg;
  cec_state_s s_next;
  logic rst_m_reg;
  logic rstn_reg;

  // Reset release through two flip-flops
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_m_reg <= 1'b0;
      rstn_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rstn_reg <= rst_m_reg;
    end
  end

  // Pump speed threshold scaled to engine speed: pump * 100 / ratio
  function automatic logic [15:0] cec_scale(input logic [15:0] pump, input logic alt);
    logic [23:0] num;
    num = 24'(pump) * 24'd100;
    cec_scale = 16'(num / 24'(alt ? cec_pkg::RATIO_B : cec_pkg::RATIO_A));
  endfunction : cec_scale

  // Hold counter; returns saturating count
  function automatic logic [24:0] cec_hold(input logic press, input logic [24:0] cnt);
    cec_hold = !press ? 25'h0 : (cnt == 25'h1ffffff ? cnt : cnt + 25'h1);
  endfunction : cec_hold

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] rpm;
  logic rpm_ok;
  logic [15:0] warn_rpm;
  logic [15:0] clr_rpm;
  logic [15:0] cut_rpm;
  logic cond_ok;
  logic over_cut;
  logic oil_shut;
  logic trip;
  logic on_fire;
  logic aw_ok;
  logic w_ok;

  always_comb begin
    rpm = s_reg.ctrl[cec_pkg::CTRL_SRC_PULSE] ? PULSE_RPM : BUS_RPM;
    rpm_ok = s_reg.ctrl[cec_pkg::CTRL_SRC_PULSE] ? PULSE_RPM_VALID : BUS_RPM_VALID;
    warn_rpm = cec_scale(s_reg.warn_pump, s_reg.ctrl[cec_pkg::CTRL_RATIO]);
    clr_rpm = cec_scale(cec_pkg::WARN_CLEAR_PUMP, s_reg.ctrl[cec_pkg::CTRL_RATIO]);
    cut_rpm = cec_scale(s_reg.cut_pump, s_reg.ctrl[cec_pkg::CTRL_RATIO]);
    // Shutdown causes; any of them drops the clutch
    over_cut = rpm_ok && (rpm > cut_rpm);
    oil_shut = TEMP_PRESENT && (OIL_F > s_reg.oil_cut);
    trip = over_cut || oil_shut || AGENT_LEVEL_LOW || TRANS_HOT
      || (s_reg.fault != cec_pkg::F_NONE);
    // Start conditions, checked when the request is made
    cond_ok = rpm_ok && (rpm <= s_reg.eng_rpm)
      && (AIR_PSI < cec_pkg::PRESS_LIMIT_PSI)
      && (OIL_F < s_reg.oil_warn)
      && (s_reg.fault == cec_pkg::F_NONE) && !trip;
    // One on/off action per completed hold, none in settings
    on_fire = s_reg.on_done && !(s_reg.mode == cec_pkg::CEC_SET)
      && INTERLOCK && !BTN_MODE;
    // Address and data are taken in either order
    aw_ok = S_AXI_AWVALID && !s_reg.aw_got;
    w_ok = S_AXI_WVALID && !s_reg.w_got;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    // Bus write path
    if (aw_ok) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = S_AXI_AWADDR;
    end
    if (w_ok) begin
      s_next.w_got = 1'b1;
      s_next.w_data = S_AXI_WDATA;
      // Strobe kept with the data, valid only with WVALID
      s_next.w_stb = S_AXI_WSTRB[0];
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = cec_pkg::RESP_OKAY;
      case (s_reg.aw_addr)
        cec_pkg::A_CTRL: if (s_reg.w_stb) s_next.ctrl = s_reg.w_data[5:0];
        cec_pkg::A_ENG_RPM: s_next.eng_rpm = s_reg.w_data[15:0];
        cec_pkg::A_WARN_PUMP: s_next.warn_pump = s_reg.w_data[15:0];
        cec_pkg::A_CUT_PUMP: s_next.cut_pump = s_reg.w_data[15:0];
        cec_pkg::A_OIL_WARN: s_next.oil_warn = s_reg.w_data[15:0];
        cec_pkg::A_OIL_CUT: s_next.oil_cut = s_reg.w_data[15:0];
        cec_pkg::A_STATUS, cec_pkg::A_FAULT, cec_pkg::A_HOURS: s_next.bresp = cec_pkg::RESP_OKAY;
        default: s_next.bresp = cec_pkg::RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && S_AXI_BREADY) s_next.bvalid = 1'b0;
    // Bus read path
    if (S_AXI_ARVALID && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = cec_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        cec_pkg::A_CTRL: s_next.rdata = {26'h0, s_reg.ctrl};
        cec_pkg::A_ENG_RPM: s_next.rdata = {16'h0, s_reg.eng_rpm};
        cec_pkg::A_WARN_PUMP: s_next.rdata = {16'h0, s_reg.warn_pump};
        cec_pkg::A_CUT_PUMP: s_next.rdata = {16'h0, s_reg.cut_pump};
        cec_pkg::A_OIL_WARN: s_next.rdata = {16'h0, s_reg.oil_warn};
        cec_pkg::A_OIL_CUT: s_next.rdata = {16'h0, s_reg.oil_cut};
        cec_pkg::A_STATUS: s_next.rdata = {16'h0, s_reg.outs, s_reg.on, s_reg.clutch,
          s_reg.engaged, s_reg.ovs_led, s_reg.mode == cec_pkg::CEC_SET};
        cec_pkg::A_FAULT: s_next.rdata = {28'h0, s_reg.fault};
        cec_pkg::A_HOURS: s_next.rdata = {14'h0, s_reg.hours};
        default: begin
          s_next.rdata = 32'h0;
          s_next.rresp = cec_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && S_AXI_RREADY) s_next.rvalid = 1'b0;

    // Faults, first missing sensor wins
    if (!rpm_ok) s_next.fault = cec_pkg::F_NO_RPM;
    else if (!PRESS_PRESENT) s_next.fault = cec_pkg::F_NO_PRESS;
    else if (!TEMP_PRESENT) s_next.fault = cec_pkg::F_NO_TEMP;
    else s_next.fault = cec_pkg::F_NONE;

    // Button hold timers
    s_next.on_cnt = cec_hold(BTN_ONOFF && !BTN_MODE && INTERLOCK, s_reg.on_cnt);
    s_next.on_done = (s_reg.on_cnt == 25'(cec_pkg::ON_HOLD_CYC - 1));
    s_next.mode_cnt = cec_hold(BTN_MODE && !BTN_ONOFF, s_reg.mode_cnt);
    s_next.mode_done = (s_reg.mode_cnt == 25'(cec_pkg::MODE_HOLD_CYC - 1));
    s_next.both_cnt = cec_hold(BTN_MODE && BTN_ONOFF, s_reg.both_cnt);
    s_next.both_done = (s_reg.both_cnt == 25'(cec_pkg::MODE_HOLD_CYC - 1));
    s_next.mode_q = BTN_MODE;
    s_next.ilk_q = INTERLOCK;

    // Operating mode and view
    case (s_reg.mode)
      cec_pkg::CEC_RUN: begin
        if (s_reg.mode_done) begin
          s_next.mode = cec_pkg::CEC_SET;
          s_next.idle_cnt = 25'h0;
        end else if (s_reg.mode_q && !BTN_MODE && s_reg.mode_cnt < 25'(cec_pkg::MODE_HOLD_CYC)
                     && !BTN_ONOFF) begin
          // Short press advances the view on release
          case (s_reg.view)
            cec_pkg::CEC_VIEW_RPM: s_next.view = cec_pkg::CEC_VIEW_AIR;
            cec_pkg::CEC_VIEW_AIR: s_next.view = cec_pkg::CEC_VIEW_HRS;
            default: s_next.view = cec_pkg::CEC_VIEW_RPM;
          endcase
        end
      end
      cec_pkg::CEC_SET: begin
        s_next.idle_cnt = (BTN_MODE || BTN_ONOFF) ? 25'h0 : s_reg.idle_cnt + 25'h1;
        if (s_reg.both_done
            || s_reg.idle_cnt == 25'(cec_pkg::IDLE_TIMEOUT_CYC - 1)) begin
          s_next.mode = cec_pkg::CEC_RUN;
        end
      end
      default: s_next.mode = cec_pkg::CEC_RUN;
    endcase

    // Engagement request
    s_next.bleed = 1'b0;
    if (on_fire && s_reg.on) s_next.on = 1'b0;
    else if (on_fire || (s_reg.ctrl[cec_pkg::CTRL_AUTO_ON] && INTERLOCK
             && !s_reg.ilk_q)) begin
      if (cond_ok) s_next.on = 1'b1;
      s_next.bleed = AIR_PSI >= cec_pkg::PRESS_LIMIT_PSI;
    end
    if (trip || !INTERLOCK) s_next.on = 1'b0;
    // Lamp lights one cycle after the clutch and goes out with it
    s_next.clutch = s_next.on;
    s_next.engaged = s_next.on && s_reg.clutch && !trip;

    // Overspeed LED with hysteresis
    if (rpm_ok && rpm > warn_rpm) s_next.ovs_led = 1'b1;
    else if (!rpm_ok || rpm <= clr_rpm) s_next.ovs_led = 1'b0;

    // Hour meter
    // Stops at its top value; the total is kept while off
    if (s_reg.clutch && s_reg.hours < cec_pkg::HOURS_MAX) begin
      if (s_reg.tenth_cnt == 32'(cec_pkg::TENTH_HOUR_CYC - 1)) begin
        s_next.tenth_cnt = 32'h0;
        s_next.hours = s_reg.hours + 18'h1;
      end else begin
        s_next.tenth_cnt = s_reg.tenth_cnt + 32'h1;
      end
    end

    // Messages and buzzer
    s_next.outs[0] = rpm_ok && rpm >= warn_rpm && rpm <= cut_rpm;
    s_next.outs[1] = over_cut;
    s_next.outs[2] = TEMP_PRESENT && OIL_F > s_reg.oil_warn && OIL_F <= s_reg.oil_cut;
    s_next.outs[3] = oil_shut;
    s_next.outs[4] = AGENT_LEVEL_LOW;
    s_next.outs[5] = TRANS_HOT;
    // Bleed message holds until pressure is below the limit
    s_next.outs[6] = s_reg.outs[6] ? !(AIR_PSI < cec_pkg::PRESS_LIMIT_PSI) || s_next.bleed
      : s_next.bleed;
    s_next.outs[7] = AIR_PSI >= cec_pkg::PRESS_LIMIT_PSI;
    s_next.outs[8] = s_reg.ovs_led || over_cut || oil_shut || s_next.outs[2]
      || AGENT_LEVEL_LOW || TRANS_HOT;
    s_next.outs[10:9] = 2'b00;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge rstn_reg) begin
    if (!rstn_reg) begin
      // Settings return to defaults, view to speed and mode to run, all else clears
      s_reg <= '0;
      s_reg.ctrl <= 6'h00;
      s_reg.eng_rpm <= cec_pkg::ENGAGE_RPM_DEF;
      s_reg.warn_pump <= cec_pkg::WARN_PUMP_DEF;
      s_reg.cut_pump <= cec_pkg::CUT_PUMP_DEF;
      s_reg.oil_warn <= cec_pkg::OIL_WARN_DEF;
      s_reg.oil_cut <= cec_pkg::OIL_CUT_DEF;
      s_reg.view <= cec_pkg::CEC_VIEW_RPM;
      s_reg.mode <= cec_pkg::CEC_RUN;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready is low only while a word is held
  assign S_AXI_AWREADY = !s_reg.aw_got;
  assign S_AXI_WREADY = !s_reg.w_got;
  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_ARREADY = !s_reg.rvalid;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign S_AXI_RDATA = s_reg.rdata;
  assign S_AXI_RRESP = s_reg.rresp;
  assign CLUTCH = s_reg.clutch;
  assign ENGAGED_LED = s_reg.engaged;
  assign OVERSPEED_LED = s_reg.ovs_led;
  assign SPEED_HIGH_WARNING = s_reg.outs[0];
  assign SPEED_CUTOUT_MESSAGE = s_reg.outs[1];
  assign OIL_HOT_WARNING = s_reg.outs[2];
  assign OIL_SHUTDOWN_MESSAGE = s_reg.outs[3];
  assign AGENT_SHUTDOWN_MESSAGE = s_reg.outs[4];
  assign TRANS_SHUTDOWN_MESSAGE = s_reg.outs[5];
  assign PRESSURE_BLEED_PENDING = s_reg.outs[6];
  assign AIR_PRESSURE_HIGH = s_reg.outs[7];
  assign BUZZER = s_reg.outs[8];
  assign FAULT_CODE = s_reg.fault;
  assign VIEW = s_reg.view;
  assign SETTINGS_MODE = (s_reg.mode == cec_pkg::CEC_SET);

endmodule : cec_top

// ---- testbench/cec_top_assertions.sv ----
`timescale 1ns/1ns
module cec_top_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Sensors and contacts
  input wire logic [15:0] BUS_RPM,
  input wire logic BUS_RPM_VALID,
  input wire logic [15:0] AIR_PSI,
  input wire logic PRESS_PRESENT,
  input wire logic [15:0] OIL_F,
  input wire logic TEMP_PRESENT,
  input wire logic INTERLOCK,
  input wire logic AGENT_LEVEL_LOW,
  input wire logic TRANS_HOT,
  // Controller outputs
  input wire logic CLUTCH,
  input wire logic ENGAGED_LED,
  input wire logic OVERSPEED_LED,
  input wire logic BUZZER,
  input wire logic [3:0] FAULT_CODE
);
  // Figures assume default limits, bus speed source and the 2.44 ratio
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  AST_LED_NEEDS_CLUTCH: assert property (ENGAGED_LED |-> $past(CLUTCH))
    else $error("engaged lamp without clutch");
  AST_SPEED_LIMIT: assert property ($rose(CLUTCH) |-> BUS_RPM <= 16'd900)
    else $error("engaged above speed limit");
  AST_PRESS_LIMIT: assert property ($rose(CLUTCH) |-> AIR_PSI < 16'd10)
    else $error("engaged with pressure");
  AST_OIL_LIMIT: assert property ($rose(CLUTCH) |-> OIL_F < 16'd212)
    else $error("engaged with hot oil");
  AST_INTERLOCK: assert property (!INTERLOCK |=> !CLUTCH)
    else $error("clutch held without interlock");
  AST_CUTOUT: assert property (BUS_RPM > 16'd1844 |-> ##[1:3] !CLUTCH)
    else $error("no cutout on overspeed");
  AST_OIL_CUT: assert property (OIL_F > 16'd240 |-> ##[1:3] !CLUTCH)
    else $error("no cutout on oil shutdown");
  AST_TRIP_INPUT: assert property ((AGENT_LEVEL_LOW || TRANS_HOT) |=> (!CLUTCH) [*2])
    else $error("clutch held on shutdown contact");
  AST_BUZZ: assert property ((AGENT_LEVEL_LOW || TRANS_HOT) |-> ##[1:3] BUZZER)
    else $error("buzzer silent on shutdown contact");
  AST_OVS_SET: assert property ($rose(OVERSPEED_LED) |-> $past(BUS_RPM) > 16'd1495)
    else $error("overspeed lamp set too low");
  AST_OVS_CLEAR: assert property ($fell(OVERSPEED_LED) |-> $past(BUS_RPM) <= 16'd1475)
    else $error("overspeed lamp cleared too high");
  AST_NO_SPEED: assert property (
    !BUS_RPM_VALID && PRESS_PRESENT && TEMP_PRESENT |-> ##[1:3] FAULT_CODE == 4'h3)
    else $error("missing speed fault code");
  AST_NO_TEMP: assert property (
    BUS_RPM_VALID && PRESS_PRESENT && !TEMP_PRESENT |-> ##[1:3] FAULT_CODE == 4'ha)
    else $error("missing temperature fault code");
endmodule : cec_top_chk
bind cec_top cec_top_chk u_chk (
  .CLK, .RSTN, .BUS_RPM, .BUS_RPM_VALID, .AIR_PSI, .PRESS_PRESENT, .OIL_F, .TEMP_PRESENT,
  .INTERLOCK, .AGENT_LEVEL_LOW, .TRANS_HOT, .CLUTCH, .ENGAGED_LED, .OVERSPEED_LED, .BUZZER,
  .FAULT_CODE
);

// ---- testbench/cec_env_model.sv ----
`timescale 1ns/1ns
module cec_env_model (
  // Clock
  input wire logic clk,
  // Engine and sensors
  output logic [15:0] rpm,
  output logic rpm_ok,
  output logic [15:0] psi,
  output logic psi_ok,
  output logic [15:0] oil,
  output logic oil_ok,
  // Contacts
  output logic ilock,
  output logic foam_low,
  output logic trans_hot,
  // Operator buttons
  output logic onoff,
  output logic mode
);
  initial begin
    {rpm, psi, oil} = {16'd800, 16'd0, 16'd100};
    {rpm_ok, psi_ok, oil_ok, ilock, foam_low, trans_hot} = 6'h38;
    {onoff, mode} = 2'b00;
  end
  task automatic set_env(input logic [15:0] r, input logic [15:0] p, input logic [15:0] t);
    @(posedge clk);
    {rpm, psi, oil} <= {r, p, t};
  endtask : set_env
  // Presence bits, interlock, foam and transmission contacts
  task automatic set_flags(input logic [5:0] f);
    @(posedge clk);
    {rpm_ok, psi_ok, oil_ok, ilock, foam_low, trans_hot} <= f;
  endtask : set_flags
  // Operator holds one button for n cycles, then lets go
  task automatic press(input logic m, input int n);
    @(posedge clk);
    mode <= m;
    onoff <= !m;
    repeat (n) @(posedge clk);
    {onoff, mode} <= 2'b00;
  endtask : press
endmodule : cec_env_model

// ---- testbench/cec_top_bench.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cec_top_bench;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
  logic [31:0] S_AXI_RDATA, rd;
  logic [15:0] BUS_RPM, AIR_PSI, OIL_F;
  logic [15:0] PULSE_RPM = 16'h0;
  logic PULSE_RPM_VALID = 1'b0;
  logic BUS_RPM_VALID, PRESS_PRESENT, TEMP_PRESENT, INTERLOCK, AGENT_LEVEL_LOW, TRANS_HOT;
  logic BTN_ONOFF, BTN_MODE, CLUTCH, ENGAGED_LED, OVERSPEED_LED, BUZZER, SPEED_HIGH_WARNING;
  logic SPEED_CUTOUT_MESSAGE, OIL_HOT_WARNING, OIL_SHUTDOWN_MESSAGE, AGENT_SHUTDOWN_MESSAGE;
  logic TRANS_SHUTDOWN_MESSAGE, SETTINGS_MODE, PRESSURE_BLEED_PENDING, AIR_PRESSURE_HIGH;
  logic [3:0] FAULT_CODE, msgs;
  logic [2:0] VIEW;
  int failures = 0, n_checks = 0;
  logic [3:0] ftab [3] = '{cec_pkg::F_NO_RPM, cec_pkg::F_NO_PRESS, cec_pkg::F_NO_TEMP};
  logic [2:0] vtab [3] = '{cec_pkg::CEC_VIEW_AIR, cec_pkg::CEC_VIEW_HRS, cec_pkg::CEC_VIEW_RPM};
  logic [15:0] btab [3][3] = '{'{16'd901, 16'd0, 16'd100}, '{16'd800, 16'd10, 16'd100},
    '{16'd800, 16'd0, 16'd212}};
  // Trip cases: speed, oil, contact flags
  logic [15:0] ttab [5][3] = '{'{16'd1845, 16'd100, 16'h3c}, '{16'd800, 16'd241, 16'h3c},
    '{16'd800, 16'd100, 16'h3e}, '{16'd800, 16'd100, 16'h3d}, '{16'd800, 16'd100, 16'h34}};
  assign msgs = {SPEED_CUTOUT_MESSAGE, OIL_SHUTDOWN_MESSAGE, AGENT_SHUTDOWN_MESSAGE,
    TRANS_SHUTDOWN_MESSAGE};
  always #50 CLK = ~CLK;
  cec_top DUT (
    .CLK, .RSTN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .BUS_RPM, .BUS_RPM_VALID, .PULSE_RPM, .PULSE_RPM_VALID, .AIR_PSI,
    .PRESS_PRESENT, .OIL_F, .TEMP_PRESENT, .INTERLOCK, .AGENT_LEVEL_LOW, .TRANS_HOT, .BTN_ONOFF,
    .BTN_MODE, .CLUTCH, .ENGAGED_LED, .OVERSPEED_LED, .BUZZER, .SPEED_HIGH_WARNING,
    .SPEED_CUTOUT_MESSAGE, .OIL_HOT_WARNING, .OIL_SHUTDOWN_MESSAGE, .AGENT_SHUTDOWN_MESSAGE,
    .TRANS_SHUTDOWN_MESSAGE, .PRESSURE_BLEED_PENDING, .AIR_PRESSURE_HIGH, .FAULT_CODE,
    .VIEW, .SETTINGS_MODE
  );
  cec_env_model u_env (
    .clk(CLK), .rpm(BUS_RPM), .rpm_ok(BUS_RPM_VALID), .psi(AIR_PSI), .psi_ok(PRESS_PRESENT),
    .oil(OIL_F), .oil_ok(TEMP_PRESENT), .ilock(INTERLOCK), .foam_low(AGENT_LEVEL_LOW),
    .trans_hot(TRANS_HOT), .onoff(BTN_ONOFF), .mode(BTN_MODE)
  );
  //////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic hang();
    failures++;
    finish_test();
  endtask : hang
  // Handshakes are sampled at the rising edge, then changed by non-blocking assignment
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge CLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    do begin
      @(posedge CLK);
      ta = S_AXI_AWVALID & S_AXI_AWREADY;
      tw = S_AXI_WVALID & S_AXI_WREADY;
      tb = S_AXI_BVALID;
      r = S_AXI_BRESP;
      S_AXI_AWVALID <= S_AXI_AWVALID & !ta;
      S_AXI_WVALID <= S_AXI_WVALID & !tw;
      S_AXI_BREADY <= !tb;
      n++;
    end while (!tb && n < 50);
    if (!tb) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tb;
    n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    do begin
      @(posedge CLK);
      ta = S_AXI_ARVALID & S_AXI_ARREADY;
      tb = S_AXI_RVALID;
      {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
      S_AXI_ARVALID <= S_AXI_ARVALID & !ta;
      S_AXI_RREADY <= !tb;
      n++;
    end while (!tb && n < 50);
    if (!tb) hang();
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a, rd, rs);
    `CHK(rd, e)
    `CHK(rs, er)
  endtask : rd_chk
  task automatic settle();
    repeat (6) @(posedge CLK);
    @(negedge CLK);
  endtask : settle
  // Interlock low then high gives auto-on a fresh rising edge
  task automatic engage();
    u_env.set_flags(6'h38);
    settle();
    u_env.set_flags(6'h3c);
    settle();
  endtask : engage
  //////////////////////////////
  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    settle();
    `CHK(VIEW, cec_pkg::CEC_VIEW_RPM)
    rd_chk(cec_pkg::A_ENG_RPM, 32'h384, cec_pkg::RESP_OKAY);
    rd_chk(cec_pkg::A_OIL_CUT, 32'hf0, cec_pkg::RESP_OKAY);
    rd_chk(8'h40, 32'h0, cec_pkg::RESP_SLVERR);
    for (int i = 0; i < 3; i++) begin
      u_env.set_flags(6'h38 ^ (6'h20 >> i));
      settle();
      `CHK(FAULT_CODE, ftab[i])
    end
    axi_wr(cec_pkg::A_CTRL, 32'h10, rs);
    for (int i = 0; i < 3; i++) begin
      u_env.set_env(btab[i][0], btab[i][1], btab[i][2]);
      engage();
      `CHK(CLUTCH, 1'b0)
      `CHK({PRESSURE_BLEED_PENDING, AIR_PRESSURE_HIGH}, {2{i == 1}})
    end
    u_env.set_env(16'd900, 16'd9, 16'd211);
    engage();
    `CHK({CLUTCH, ENGAGED_LED}, 2'b11)
    u_env.set_env(16'd1500, 16'd9, 16'd220);
    settle();
    `CHK({CLUTCH, SPEED_HIGH_WARNING, OIL_HOT_WARNING}, 3'b111)
    `CHK({OVERSPEED_LED, BUZZER}, 2'b11)
    u_env.set_env(16'd1480, 16'd9, 16'd220);
    settle();
    `CHK(OVERSPEED_LED, 1'b1)
    u_env.set_env(16'd1475, 16'd9, 16'd220);
    settle();
    `CHK(OVERSPEED_LED, 1'b0)
    for (int k = 0; k < 5; k++) begin
      u_env.set_env(16'd800, 16'd0, 16'd100);
      engage();
      `CHK(CLUTCH, 1'b1)
      u_env.set_env(ttab[k][0], 16'd0, ttab[k][1]);
      u_env.set_flags(ttab[k][2][5:0]);
      settle();
      `CHK({CLUTCH, ENGAGED_LED}, 2'b00)
      `CHK(msgs, 4'b1000 >> k)
      `CHK(BUZZER, k < 4)
    end
    u_env.set_flags(6'h3c);
    for (int i = 0; i < 3; i++) begin
      u_env.press(1'b1, 20);
      settle();
      `CHK(VIEW, vtab[i])
    end
    `CHK(SETTINGS_MODE, 1'b0)
    engage();
    u_env.press(1'b0, 20);
    settle();
    `CHK(CLUTCH, 1'b1)
    axi_wr(cec_pkg::A_CTRL, 32'h18, rs);
    axi_wr(cec_pkg::A_ENG_RPM, 32'h3e8, rs);
    rd_chk(cec_pkg::A_ENG_RPM, 32'h3e8, cec_pkg::RESP_OKAY);
    axi_wr(8'h40, 32'h1, rs);
    `CHK(rs, cec_pkg::RESP_SLVERR)
    engage();
    u_env.set_env(16'd1685, 16'd0, 16'd100);
    settle();
    `CHK(CLUTCH, 1'b1)
    u_env.set_env(16'd1686, 16'd0, 16'd100);
    settle();
    `CHK(CLUTCH, 1'b0)
    u_env.set_env(16'd800, 16'd0, 16'd100);
    axi_wr(cec_pkg::A_CTRL, 32'h28, rs);
    settle();
    `CHK(FAULT_CODE, cec_pkg::F_NO_RPM)
    @(posedge CLK);
    PULSE_RPM_VALID <= 1'b1;
    settle();
    `CHK(FAULT_CODE, cec_pkg::F_NONE)
    finish_test();
  end
endmodule : cec_top_bench
